// *** hdl/fsr_pkg.sv ***
// Shared constants, types and decode tables for the front-end setup register bank.
package fsr_pkg;

	// Byte addresses of the Wishbone register map.
	localparam logic [7:0] FSR_ADR_SETUP  = 8'h00; // Front-end setup word, read/write.
	localparam logic [7:0] FSR_ADR_STATUS = 8'h04; // Decoded setup and sanity flags, read only.
	localparam logic [7:0] FSR_ADR_CHAN0  = 8'h08; // Readout channel zero, read only.
	localparam logic [7:0] FSR_ADR_CHAN1  = 8'h0c; // Readout channel one, read only.
	localparam logic [7:0] FSR_ADR_CHAN2  = 8'h10; // Readout channel two, read only.

	// Field positions inside the setup word.
	localparam int FSR_LOCK_BIT    = 15; // Memory-lock flag; setup writes are not blocked.
	localparam int FSR_CLUSTER_BIT = 8;  // Channel grouping option.
	localparam int FSR_MOD_LSB     = 6;  // Modulo select, two bits.
	localparam int FSR_RATE_LSB    = 4;  // Sample rate select, two bits.
	localparam int FSR_MEAS_LSB    = 0;  // Measurement setup, four bits.

	// Reset value of the setup word and the mask of bits that are actually stored.
	localparam logic [15:0] FSR_SETUP_RESET = 16'h0000;
	localparam logic [15:0] FSR_SETUP_MASK  = 16'h81ff;

	// Modulo wrap range in degrees for each select code.
	localparam logic [8:0] FSR_DEG_360 = 9'h168;
	localparam logic [8:0] FSR_DEG_90  = 9'h05a;
	localparam logic [8:0] FSR_DEG_120 = 9'h078;
	localparam logic [8:0] FSR_DEG_180 = 9'h0b4;

	// Converter sample rate in kSps for each select code.
	localparam logic [4:0] FSR_KSPS_2  = 5'h02;
	localparam logic [4:0] FSR_KSPS_4  = 5'h04;
	localparam logic [4:0] FSR_KSPS_8  = 5'h08;
	localparam logic [4:0] FSR_KSPS_16 = 5'h10;

	// Measurement setups that the datapath understands.
	typedef enum logic [2:0] {
		FSR_MODE_NONE    = 3'h0, // Unused or reserved code.
		FSR_MODE_PLANAR  = 3'h1, // Two-channel plain planar.
		FSR_MODE_SFC     = 3'h2, // Two-channel stray-field compensated.
		FSR_MODE_VCP     = 3'h3, // Two-channel virtual centre pixel.
		FSR_MODE_ROTARY  = 3'h4, // Compensated rotary, 180 degree limit.
		FSR_MODE_ATAN    = 3'h5, // Three-channel arctangent angle.
		FSR_MODE_JOY     = 3'h6, // Three-channel joystick.
		FSR_MODE_RAW     = 3'h7  // Three-channel raw values.
	} fsr_mode_t;

	// Hall-plate combinations that can feed one channel.
	typedef enum logic [3:0] {
		FSR_PL_NONE  = 4'h0, FSR_PL_X1    = 4'h1, FSR_PL_Y1    = 4'h2, FSR_PL_Z1    = 4'h3,
		FSR_PL_Z4Z1D = 4'h4, FSR_PL_X4X1D = 4'h5, FSR_PL_Y4Y1D = 4'h6, FSR_PL_X1X4S = 4'h7,
		FSR_PL_Y1Y4S = 4'h8, FSR_PL_Z1Z4S = 4'h9, FSR_PL_Z2Z5S = 4'ha, FSR_PL_Z3Z6S = 4'hb,
		FSR_PL_Z3    = 4'hc, FSR_PL_Z5    = 4'hd
	} fsr_plate_t;

	// Decoded configuration handed to the datapath.
	typedef struct packed {
		logic       locked;    // Configuration memory locked.
		logic       cluster;   // Channels refresh as a group.
		logic [8:0] wrap_deg;  // Output wrap range in degrees.
		logic [4:0] rate_ksps; // Converter rate in kSps.
		fsr_mode_t  mode;      // Measurement setup.
		fsr_plate_t ch1;       // Plate source of channel 1.
		fsr_plate_t ch2;       // Plate source of channel 2.
		fsr_plate_t ch3;       // Plate source of channel 3.
		logic       bad_code;  // Setup code is reserved.
		logic       bad_rate;  // Top rate chosen without the raw setup.
	} fsr_cfg_t;

	// Bus FSM states, one-hot.
	typedef enum logic [1:0] {
		FSR_BUS_IDLE = 2'b01,
		FSR_BUS_ACK  = 2'b10
	} fsr_bus_t;

endpackage : fsr_pkg

// *** hdl/fsr_frontend_setup.sv ***
// Front-end setup register bank with Wishbone slave and readout channel grouping.
// How it works
// - Bit 15 flags the configuration memory locked.
// - Grouping bit picks independent or grouped channel refresh.
// - Bits 7:6 pick 360, 90, 120, 180 wrap.
// - Bits 5:4 pick 2, 4, 8, 16 kSps.
// - Codes 0000-0111 other than 0011 and 0110 decode to planar setups; 0011 is reserved.
// - Code 0110 selects compensated 180 degree rotary.
// - Codes 1010, 1001, 1110 select spatial modes.
`timescale 1ns/1ps
module fsr_frontend_setup
	import fsr_pkg::*;
(
	input  wire logic             clock,       // System clock, 250 MHz.
	input  wire logic             srst,        // Synchronous reset, active high.
	input  wire logic             wb_cyc,      // Wishbone cycle.
	input  wire logic             wb_stb,      // Wishbone strobe.
	input  wire logic             wb_we,       // Wishbone write enable.
	input  wire logic [7:0]       wb_adr,      // Wishbone byte address.
	input  wire logic [3:0]       wb_sel,      // Wishbone byte selects.
	input  wire logic [31:0]      wb_dat_w,    // Wishbone write data.
	output logic      [31:0]      wb_dat_r,    // Wishbone read data.
	output logic                  wb_ack,      // Wishbone acknowledge.
	input  wire logic [2:0]       smp_valid,   // New sample per channel, one-cycle pulse.
	input  wire logic [2:0][15:0] smp_data,    // Sample values per channel.
	output fsr_cfg_t              cfg          // Decoded configuration for the datapath.
);

	// Decode of the setup word into the datapath configuration.
	function automatic fsr_cfg_t decode_setup(input logic [15:0] w);
		fsr_cfg_t c;
		c           = '0;
		c.locked    = w[FSR_LOCK_BIT];
		c.cluster   = w[FSR_CLUSTER_BIT];
		case (w[FSR_MOD_LSB +: 2])
			2'b00:   c.wrap_deg = FSR_DEG_360;
			2'b01:   c.wrap_deg = FSR_DEG_90;
			2'b10:   c.wrap_deg = FSR_DEG_120;
			default: c.wrap_deg = FSR_DEG_180;
		endcase
		case (w[FSR_RATE_LSB +: 2])
			2'b00:   c.rate_ksps = FSR_KSPS_2;
			2'b01:   c.rate_ksps = FSR_KSPS_4;
			2'b10:   c.rate_ksps = FSR_KSPS_8;
			default: c.rate_ksps = FSR_KSPS_16;
		endcase
		// Codes listed as setups win over the blanket reservation; the rest decode to none.
		case (w[FSR_MEAS_LSB +: 4])
			4'h0, 4'h1:
			begin
				c.mode = FSR_MODE_PLANAR;
				c.ch1  = (w[0]) ? FSR_PL_Z1 : FSR_PL_X1;
				c.ch2  = FSR_PL_Y1;
			end
			4'h2, 4'h4:
			begin
				c.mode = FSR_MODE_SFC;
				c.ch1  = (w[2]) ? FSR_PL_X4X1D : FSR_PL_Z4Z1D;
				c.ch2  = (w[2]) ? FSR_PL_Y4Y1D : FSR_PL_X4X1D;
			end
			4'h5, 4'h7:
			begin
				c.mode = FSR_MODE_VCP;
				c.ch1  = FSR_PL_X1X4S;
				c.ch2  = FSR_PL_Y1Y4S;
			end
			4'h6:
			begin
				c.mode = FSR_MODE_ROTARY;
				c.ch1  = FSR_PL_Z1Z4S;
				c.ch2  = FSR_PL_Z2Z5S;
				c.ch3  = FSR_PL_Z3Z6S;
			end
			4'ha, 4'h9, 4'he:
			begin
				c.mode = (w[3:0] == 4'ha) ? FSR_MODE_ATAN : (w[3:0] == 4'h9) ? FSR_MODE_JOY : FSR_MODE_RAW;
				c.ch1  = FSR_PL_Z1;
				c.ch2  = FSR_PL_X1;
				c.ch3  = FSR_PL_Y1;
			end
			default:
			begin
				c.mode     = FSR_MODE_NONE;
				c.bad_code = 1'b1;
			end
		endcase
		// Flag the top rate when the setup cannot run it.
		c.bad_rate = (w[FSR_RATE_LSB +: 2] == 2'b11) && (c.mode != FSR_MODE_RAW);
		return c;
	endfunction : decode_setup

	// Bus state.
	fsr_bus_t         bus_q,    bus_d;    // Bus FSM.
	logic             ack_q,    ack_d;    // Acknowledge flop.
	logic [31:0]      rdat_q,   rdat_d;   // Read data flop.
	// Register state.
	logic [15:0]      setup_q,  setup_d;  // Stored setup word.
	fsr_cfg_t         cfg_q,    cfg_d;    // Registered decode.
	logic [2:0][15:0] chan_q,   chan_d;   // Readout channels seen by software.
	logic [2:0][15:0] stage_q,  stage_d;  // Newest samples waiting for a grouped refresh.
	// Bus events.
	logic             req_new;            // Fresh request awaiting its answer.
	logic             wr_setup;           // Setup write taken this edge.
	logic             rd_chan0;           // Channel zero read taken this edge.

	// A request is answered one cycle after it appears; taken at the edge where ack is high.
	assign req_new  = wb_cyc && wb_stb && !ack_q;
	assign wr_setup = wb_cyc && wb_stb && ack_q && wb_we && (wb_adr == FSR_ADR_SETUP);
	assign rd_chan0 = wb_cyc && wb_stb && ack_q && !wb_we && (wb_adr == FSR_ADR_CHAN0);

	// Bus FSM next state, acknowledge and read mux; unmapped reads return zero.
	always_comb
	begin
		bus_d  = bus_q;
		ack_d  = 1'b0;
		rdat_d = 32'h0000_0000;
		case (bus_q)
			FSR_BUS_IDLE:
			begin
				if (req_new)
				begin
					bus_d = FSR_BUS_ACK;
					ack_d = 1'b1;
					case (wb_adr)
						FSR_ADR_SETUP:  rdat_d = {16'h0000, setup_q};
						// Status is 21 bits wide, so eleven zero bits fill the word up to 32.
						FSR_ADR_STATUS: rdat_d = {11'h000, cfg_q.bad_rate, cfg_q.bad_code, cfg_q.mode,
						                          cfg_q.rate_ksps, cfg_q.wrap_deg, cfg_q.cluster, cfg_q.locked};
						FSR_ADR_CHAN0:  rdat_d = {16'h0000, chan_q[0]};
						FSR_ADR_CHAN1:  rdat_d = {16'h0000, chan_q[1]};
						FSR_ADR_CHAN2:  rdat_d = {16'h0000, chan_q[2]};
						default:        rdat_d = 32'h0000_0000;
					endcase
				end
			end
			FSR_BUS_ACK:
			begin
				// Ack drops after one cycle so the master sees exactly one edge.
				bus_d = FSR_BUS_IDLE;
			end
			default:
			begin
				bus_d = FSR_BUS_IDLE;
			end
		endcase
	end

	// Bus state registers.
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			bus_q  <= FSR_BUS_IDLE;
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end
		else
		begin
			bus_q  <= bus_d;
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack   = ack_q;
	assign wb_dat_r = rdat_q;

	// Setup word: byte lanes 0 and 1 write, the must-be-zero bits are never stored.
	always_comb
	begin
		setup_d = setup_q;
		if (wr_setup)
		begin
			if (wb_sel[0])
			begin
				setup_d[7:0] = wb_dat_w[7:0];
			end
			if (wb_sel[1])
			begin
				setup_d[15:8] = wb_dat_w[15:8];
			end
			setup_d = setup_d & FSR_SETUP_MASK;
		end
		cfg_d = decode_setup(setup_q);
	end

	// Readout channels: direct update, or staged and copied as a group when channel zero is read.
	always_comb
	begin
		chan_d  = chan_q;
		stage_d = stage_q;
		for (int i = 0; i < 3; i++)
		begin
			if (smp_valid[i])
			begin
				stage_d[i] = smp_data[i];
				if (!cfg_q.cluster)
				begin
					chan_d[i] = smp_data[i];
				end
			end
		end
		// The group copy uses the staged values before this cycle's samples land.
		if (cfg_q.cluster && rd_chan0)
		begin
			chan_d = stage_q;
		end
	end

	// Register file and channel flops.
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			setup_q <= FSR_SETUP_RESET;
			cfg_q   <= '0;
			chan_q  <= '0;
			stage_q <= '0;
		end
		else
		begin
			setup_q <= setup_d;
			cfg_q   <= cfg_d;
			chan_q  <= chan_d;
			stage_q <= stage_d;
		end
	end

	assign cfg = cfg_q;

	// Checks.
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	sequence req_seen;
		wb_cyc && wb_stb && !ack_q;
	endsequence

	sequence ack_pulse;
		ack_q ##1 !ack_q;
	endsequence

	ack_timing_a: assert property (req_seen |=> ack_pulse)
		else $error("Acknowledge not one cycle after request.");

	setup_store_a: assert property (wr_setup && wb_sel[1:0] == 2'b11 |=>
		setup_q == (($past(wb_dat_w[15:0])) & FSR_SETUP_MASK))
		else $error("Setup write stored wrong value.");

	lock_follow_a: assert property ($past(setup_q[15]) == cfg_q.locked)
		else $error("Lock flag does not follow setup bit.");

	wrap_range_a: assert property ($past(setup_q[7:6]) == 2'b01 |-> cfg_q.wrap_deg == 9'h05a)
		else $error("Modulo 90 not decoded.");

	rate_sel_a: assert property ($past(setup_q[5:4]) == 2'b10 |-> cfg_q.rate_ksps == 5'h08)
		else $error("Rate 8 kSps not decoded.");

	planar_mode_a: assert property ($past(setup_q[3:0]) == 4'h5 |-> cfg_q.mode == FSR_MODE_VCP)
		else $error("Virtual centre pixel not decoded.");

	rotary_mode_a: assert property ($past(setup_q[3:0]) == 4'h6 |-> cfg_q.mode == FSR_MODE_ROTARY)
		else $error("Rotary setup not decoded.");

	raw_plates_a: assert property (cfg_q.mode == FSR_MODE_RAW |->
		cfg_q.ch1 == FSR_PL_Z1 && cfg_q.ch2 == FSR_PL_X1 && cfg_q.ch3 == FSR_PL_Y1)
		else $error("Raw setup plate routing wrong.");

	indep_update_a: assert property (!cfg_q.cluster && smp_valid[1] |=> chan_q[1] == $past(smp_data[1]))
		else $error("Independent channel did not update.");

	group_hold_a: assert property (cfg_q.cluster && !rd_chan0 |=> $stable(chan_q))
		else $error("Grouped channels changed without channel zero read.");

endmodule : fsr_frontend_setup

// *** tb/fsr_frontend_setup_test.sv ***
// Self-checking testbench for the front-end setup register bank.
`timescale 1ns/1ps
module fsr_frontend_setup_test
	import fsr_pkg::*;
;
	logic             clock;      // Bench clock, 4 ns period.
	logic             srst;       // Synchronous reset.
	logic             wb_cyc;     // Bus cycle.
	logic             wb_stb;     // Bus strobe.
	logic             wb_we;      // Bus direction.
	logic [7:0]       wb_adr;     // Bus address.
	logic [3:0]       wb_sel;     // Bus byte selects.
	logic [31:0]      wb_dat_w;   // Bus write data.
	logic [31:0]      wb_dat_r;   // Bus read data.
	logic             wb_ack;     // Bus acknowledge.
	logic [2:0]       smp_valid;  // Sample pulses.
	logic [2:0][15:0] smp_data;   // Sample values.
	fsr_cfg_t         cfg;        // Decoded configuration.
	logic [31:0]      rd;         // Last read word.
	logic [3:0]       wr_sel;     // Byte selects for the next transfer.
	int               n_mismatch; // Mismatches seen.
	int               n_compared; // Comparisons made.
	int               n_cycles;   // Cycles since start, for the hang guard.

	fsr_frontend_setup dut (.clock(clock), .srst(srst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
		.wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
		.smp_valid(smp_valid), .smp_data(smp_data), .cfg(cfg));

	// The clock toggles every half period.
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// Prints the counts and the verdict, then stops.
	task wrap_up();
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	// A hung handshake would stall the run forever, so a cycle ceiling cuts it short.
	always @(posedge clock)
	begin
		n_cycles <= n_cycles + 1;
		if (n_cycles == 20000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	// Compares a seen value with the expected one.
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// One classic cycle; entered just after an edge, holds until ack is sampled high.
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		wb_cyc   <= 1'b1;
		wb_stb   <= 1'b1;
		wb_we    <= we;
		wb_adr   <= adr;
		wb_dat_w <= dat;
		wb_sel   <= wr_sel;
		do @(posedge clock); while (wb_ack !== 1'b1);
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
		@(posedge clock);
	endtask : wb_xfer

	// Writes the setup word and waits until the registered decode has caught up.
	task put(input logic [15:0] v);
		wb_xfer(1'b1, FSR_ADR_SETUP, {16'h0000, v});
		repeat (2) @(posedge clock);
	endtask : put

	// Pulses new samples on the selected channels for one cycle.
	task pulse(input logic [2:0] m, input logic [15:0] d0, input logic [15:0] d1, input logic [15:0] d2);
		smp_valid <= m;
		smp_data  <= {d2, d1, d0};
		@(posedge clock);
		smp_valid <= 3'h0;
		@(posedge clock);
	endtask : pulse

	// Expected decode of each measurement setup code; 1010 and 1110 keep their listed modes.
	function automatic fsr_mode_t exp_mode(input logic [3:0] c);
		case (c)
			4'h0, 4'h1: return FSR_MODE_PLANAR;
			4'h2, 4'h4: return FSR_MODE_SFC;
			4'h5, 4'h7: return FSR_MODE_VCP;
			4'h6:       return FSR_MODE_ROTARY;
			4'ha:       return FSR_MODE_ATAN;
			4'h9:       return FSR_MODE_JOY;
			4'he:       return FSR_MODE_RAW;
			default:    return FSR_MODE_NONE;
		endcase
	endfunction : exp_mode

	// Every wrap and rate code, with the raw setup so the top rate stays legal.
	task t_fields();
		logic [3:0][8:0] wrap_tab;
		logic [3:0][4:0] rate_tab;
		wrap_tab = {FSR_DEG_180, FSR_DEG_120, FSR_DEG_90, FSR_DEG_360};
		rate_tab = {FSR_KSPS_16, FSR_KSPS_8, FSR_KSPS_4, FSR_KSPS_2};
		for (int i = 0; i < 4; i++)
			for (int j = 0; j < 4; j++)
			begin
				put({8'h00, 2'(i), 2'(j), 4'he});
				check(32'(cfg.wrap_deg), 32'(wrap_tab[i]), "wrap");
				check(32'(cfg.rate_ksps), 32'(rate_tab[j]), "rate");
				check(32'(cfg.bad_rate), 32'h0, "rate legal");
			end
		put(16'h0030);
		check(32'(cfg.bad_rate), 32'h1, "top rate planar");
		$display("Test fields done");
	endtask : t_fields

	// Every setup code, reserved ones flagged.
	task t_modes();
		for (int c = 0; c < 16; c++)
		begin
			put({12'h000, 4'(c)});
			check(32'(cfg.mode), 32'(exp_mode(4'(c))), "mode");
			check(32'(cfg.bad_code), 32'(exp_mode(4'(c)) == FSR_MODE_NONE), "bad code");
		end
		$display("Test modes done");
	endtask : t_modes

	// Lock flag, must-be-zero bits and an unmapped address.
	task t_lock();
		put(16'hfe0e);
		wb_xfer(1'b0, FSR_ADR_SETUP, 32'h0);
		check(rd, 32'h0000800e, "masked readback");
		check(32'(cfg.locked), 32'h1, "locked");
		wb_xfer(1'b0, FSR_ADR_STATUS, 32'h0);
		check(rd, 32'h000715a1, "status word");
		wr_sel = 4'h1;
		put(16'hffaa);
		wr_sel = 4'hf;
		wb_xfer(1'b0, FSR_ADR_SETUP, 32'h0);
		check(rd, 32'h000080aa, "low lane write");
		put(16'h000e);
		check(32'(cfg.locked), 32'h0, "unlocked");
		wb_xfer(1'b0, 8'h20, 32'h0);
		check(rd, 32'h0, "unmapped read");
		$display("Test lock done");
	endtask : t_lock

	// Independent refresh, then grouped refresh released by a channel-zero read.
	task t_chan();
		put(16'h0000);
		pulse(3'h7, 16'h1111, 16'h2222, 16'h3333);
		wb_xfer(1'b0, FSR_ADR_CHAN1, 32'h0);
		check(rd, 32'h2222, "independent chan1");
		put(16'h0100);
		check(32'(cfg.cluster), 32'h1, "cluster flag");
		pulse(3'h7, 16'haaaa, 16'hbbbb, 16'hcccc);
		wb_xfer(1'b0, FSR_ADR_CHAN1, 32'h0);
		check(rd, 32'h2222, "held chan1");
		wb_xfer(1'b0, FSR_ADR_CHAN0, 32'h0);
		check(rd, 32'h1111, "old chan0");
		wb_xfer(1'b0, FSR_ADR_CHAN1, 32'h0);
		check(rd, 32'hbbbb, "grouped chan1");
		wb_xfer(1'b0, FSR_ADR_CHAN2, 32'h0);
		check(rd, 32'hcccc, "grouped chan2");
		wb_xfer(1'b0, FSR_ADR_CHAN0, 32'h0);
		check(rd, 32'haaaa, "grouped chan0");
		$display("Test channels done");
	endtask : t_chan

	// Main sequence: reset, then the scenarios in turn.
	initial
	begin
		{n_mismatch, n_compared} = '0;
		wr_sel = 4'hf;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w, smp_valid, smp_data} = '0;
		srst = 1'b1;
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		wb_xfer(1'b0, FSR_ADR_SETUP, 32'h0);
		check(rd, 32'h0, "setup reset");
		check(32'(cfg.mode), 32'(FSR_MODE_PLANAR), "reset mode");
		$display("Test reset done");
		t_fields();
		t_modes();
		t_lock();
		t_chan();
		wrap_up();
	end
endmodule : fsr_frontend_setup_test
